// file: srw_params.svh
/*
 Constants for the supervisor reset and watchdog timing block.
 Assumes a 100 MHz mclk; included by the supervisor design file only.
*/
`ifndef SRW_PARAMS_SVH
`define SRW_PARAMS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define SRW_CLK_MHZ 100

// ----------------------------------------
// Times in ms as printed
// ----------------------------------------
`define SRW_NV_WRITE_TYP_MS 5
`define SRW_NV_WRITE_MAX_MS 10
`define SRW_RESET_TYP_MS 250
`define SRW_WDT_SEL10_TYP_MS 250
`define SRW_WDT_SEL01_TYP_MS 650
`define SRW_WDT_SEL00_TYP_MS 1500
`define SRW_TRIP_RECOVERY_MS 10

// ----------------------------------------
// Cycle counts derived from time and rate
// ----------------------------------------
`define SRW_MS_TO_CYC(ms) ((ms) * 1000 * `SRW_CLK_MHZ)
`define SRW_NV_WRITE_CYC `SRW_MS_TO_CYC(`SRW_NV_WRITE_TYP_MS)
`define SRW_RESET_CYC `SRW_MS_TO_CYC(`SRW_RESET_TYP_MS)
`define SRW_WDT_SEL10_CYC `SRW_MS_TO_CYC(`SRW_WDT_SEL10_TYP_MS)
`define SRW_WDT_SEL01_CYC `SRW_MS_TO_CYC(`SRW_WDT_SEL01_TYP_MS)
`define SRW_WDT_SEL00_CYC `SRW_MS_TO_CYC(`SRW_WDT_SEL00_TYP_MS)

// ----------------------------------------
// Shipped watchdog selection: off
// ----------------------------------------
`define SRW_WDT_SEL_SHIPPED 2'h3

`endif

// file: srw_pkg.sv
/*
 Types for the supervisor reset and watchdog timing block.
 Assumes srw_params.svh is on the include path.
*/
package srw_pkg;
	typedef enum logic [1:0] {
		SRW_WDT_LONG,
		SRW_WDT_MID,
		SRW_WDT_SHORT,
		SRW_WDT_OFF
	} srw_wdt_sel_t;

	typedef enum logic [1:0] {
		SRW_NV_IDLE,
		SRW_NV_BUSY
	} srw_nv_state_t;
endpackage

// file: srw_timer.sv
/*
 One-shot down counter, reused for every interval of the block.
 Assumes start and load are synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module srw_timer #(
	parameter int W = 28
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic [W-1:0] load,
	output var logic busy,
	output var logic done
);
	logic [W-1:0] cnt_q;
	logic busy_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else if (start) begin
			cnt_q <= load;
			busy_q <= 1'b1;
		end else if (busy_q) begin
			cnt_q <= cnt_q - W'(1);
			busy_q <= (cnt_q > W'(1));
		end
	end

	always_comb begin
		busy = busy_q;
		done = busy_q && (cnt_q == W'(1));
	end
endmodule
`default_nettype wire

// file: srw_supervisor.sv
/*
 Reset generation, watchdog and nonvolatile write timing of a supervisor.
 Assumes all inputs are synchronous to mclk and rst models power-up.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srw_params.svh"
module srw_supervisor #(
	parameter int unsigned RESET_CYC = `SRW_RESET_CYC,
	parameter int unsigned NV_WRITE_CYC = `SRW_NV_WRITE_CYC,
	parameter int unsigned TRIP_RECOVERY_CYC =
		`SRW_MS_TO_CYC(`SRW_TRIP_RECOVERY_MS),
	parameter int unsigned WDT_SEL10_CYC = `SRW_WDT_SEL10_CYC,
	parameter int unsigned WDT_SEL01_CYC = `SRW_WDT_SEL01_CYC,
	parameter int unsigned WDT_SEL00_CYC = `SRW_WDT_SEL00_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic watchdog_kick,
	input wire logic nv_write_stop,
	input wire logic [1:0] nv_watchdog_sel,
	input wire logic write_enable_set,
	input wire logic write_enable_clr,
	input wire logic trip_program_req,
	output var logic reset_out,
	output var logic nv_busy,
	output var logic write_enable_latch,
	output var logic trip_program_done,
	output var srw_pkg::srw_wdt_sel_t watchdog_sel
);
	import srw_pkg::*;

	localparam int W = 28;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic reset_q, reset_d;
	logic busy_q, wel_q, tdone_q, kicked_q;
	srw_wdt_sel_t sel_q;
	srw_nv_state_t nv_q;
	logic rst_q_pulse, trip_q, tdone_d;
	logic rst_done, wdt_busy, wdt_done;
	logic nv_done, rec_busy;
	// Timer busy flags are left open where a state bit says the same

	// ----------------------------------------
	// Input gating
	// ----------------------------------------
	// Nothing from outside but nv_watchdog_sel is seen while reset drives the host high
	wire live = !reset_q;
	wire kick = live && watchdog_kick;
	wire stop_ok = live && nv_write_stop && (nv_q == SRW_NV_IDLE);
	wire wel_set = live && write_enable_set;
	wire wel_clr = live && write_enable_clr;
	// Busy ignores new writes; host must wait or poll nv_busy
	wire trip_ok = live && trip_program_req && wel_q && !rec_busy
		&& (nv_q == SRW_NV_IDLE);
	wire nv_start = stop_ok || trip_ok;

	// ----------------------------------------
	// Watchdog period select
	// ----------------------------------------
	wire wdt_on = (sel_q != SRW_WDT_OFF);
	wire [W-1:0] wdt_load =
		(sel_q == SRW_WDT_SHORT) ? W'(WDT_SEL10_CYC) :
		(sel_q == SRW_WDT_MID) ? W'(WDT_SEL01_CYC) :
		W'(WDT_SEL00_CYC);
	// Restart on kick, on reset end and when first armed
	wire wdt_start = wdt_on && (kick || rst_done || (live && !wdt_busy
		&& !kicked_q));
	wire wdt_fire = wdt_on && wdt_done && !kick && live;
	wire rst_start = rst_q_pulse || wdt_fire;

	// One timer shape for every interval keeps their end points alike
	srw_timer #(.W(W)) u_rst (
		.mclk(mclk), .rst(rst), .start(rst_start),
		.load(W'(RESET_CYC)), .busy(), .done(rst_done)
	);
	srw_timer #(.W(W)) u_wdt (
		.mclk(mclk), .rst(rst), .start(wdt_start),
		.load(wdt_load), .busy(wdt_busy), .done(wdt_done)
	);
	srw_timer #(.W(W)) u_nv (
		.mclk(mclk), .rst(rst), .start(nv_start),
		.load(W'(NV_WRITE_CYC)), .busy(), .done(nv_done)
	);
	srw_timer #(.W(W)) u_rec (
		.mclk(mclk), .rst(rst), .start(tdone_d),
		.load(W'(TRIP_RECOVERY_CYC)), .busy(rec_busy), .done()
	);
	// Recovery runs from the end of each trip write, not its start

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	always_comb begin
		reset_d = reset_q;
		if (rst_start)
			reset_d = 1'b1;
		else if (rst_done)
			reset_d = 1'b0;
		tdone_d = trip_q && nv_done;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			reset_q <= 1'b1;
			rst_q_pulse <= 1'b1;
			nv_q <= SRW_NV_IDLE;
			wel_q <= 1'b0;
			trip_q <= 1'b0;
			tdone_q <= 1'b0;
			kicked_q <= 1'b0;
			sel_q <= srw_wdt_sel_t'(`SRW_WDT_SEL_SHIPPED);
			busy_q <= 1'b0;
		end else begin
			rst_q_pulse <= 1'b0;
			reset_q <= reset_d;
			if (nv_start)
				nv_q <= SRW_NV_BUSY;
			else if (nv_done)
				nv_q <= SRW_NV_IDLE;
			if (trip_ok)
				trip_q <= 1'b1;
			else if (nv_done)
				trip_q <= 1'b0;
			tdone_q <= tdone_d;
			// Set wins over clear
			if (wel_set)
				wel_q <= 1'b1;
			else if (wel_clr)
				wel_q <= 1'b0;
			// Selection is taken only while no watchdog interval runs
			if (!wdt_busy)
				sel_q <= srw_wdt_sel_t'(nv_watchdog_sel);
			kicked_q <= wdt_busy || wdt_start;
			busy_q <= nv_start || (nv_q == SRW_NV_BUSY && !nv_done);
		end
	end

	always_comb begin
		reset_out = reset_q;
		nv_busy = busy_q;
		write_enable_latch = wel_q;
		trip_program_done = tdone_q;
		watchdog_sel = sel_q;
	end
endmodule
`default_nettype wire

// file: srw_supervisor_assertions.sv
/* Port checker for the supervisor, bound into it.
 Assumes the counts handed on are the design's own. */
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor_assertions #(parameter int RESET_CYC = 20,
	NV_WRITE_CYC = 20, WDT_SEL10_CYC = 40, WDT_SEL01_CYC = 60,
	WDT_SEL00_CYC = 80) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic watchdog_kick,
	input wire logic nv_write_stop,
	input wire logic trip_program_req,
	input wire logic reset_out,
	input wire logic nv_busy,
	input wire logic write_enable_latch,
	input wire logic trip_program_done,
	input wire srw_pkg::srw_wdt_sel_t watchdog_sel
);
	import srw_pkg::*;
	int bc_q, rc_q, wc_q, exp_w;
	logic ok_q;
	// Spans allow a few cycles, as edge offsets differ per design
	assign exp_w = watchdog_sel == SRW_WDT_SHORT ? WDT_SEL10_CYC :
		watchdog_sel == SRW_WDT_MID ? WDT_SEL01_CYC : WDT_SEL00_CYC;
	always_ff @(posedge mclk) begin
		bc_q <= rst || !nv_busy ? 0 : bc_q + 1;
		rc_q <= rst || !reset_out ? 0 : rc_q + 1;
		wc_q <= rst || reset_out || watchdog_kick ? 0 : wc_q + 1;
		ok_q <= !rst && (trip_program_req && write_enable_latch
			|| ok_q && !trip_program_done);
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_start;
		nv_write_stop && !nv_busy && !reset_out |=> nv_busy; endproperty
	a_start: assert property (p_start)
		else $error("write did not start");
	property p_len;
		$fell(nv_busy) |-> (bc_q - NV_WRITE_CYC + 2) inside {[0:4]}; endproperty
	a_len: assert property (p_len)
		else $error("write length wrong");
	property p_hold;
		$fell(reset_out) |-> (rc_q - RESET_CYC + 2) inside {[0:4]}; endproperty
	a_hold: assert property (p_hold)
		else $error("reset length wrong");
	property p_ign;
		reset_out |=> !$rose(nv_busy) && !$rose(write_enable_latch);
	endproperty
	a_ign: assert property (p_ign)
		else $error("input taken in reset");
	property p_off;
		watchdog_sel == SRW_WDT_OFF && !reset_out |=> !reset_out; endproperty
	a_off: assert property (p_off)
		else $error("disabled watchdog fired");
	property p_wdt;
		$rose(reset_out) |-> (wc_q - exp_w + 3) inside {[0:6]}; endproperty
	a_wdt: assert property (p_wdt)
		else $error("watchdog period wrong");
	property p_trip;
		trip_program_done |-> ok_q; endproperty
	a_trip: assert property (p_trip)
		else $error("trip done without latch");
endmodule
bind srw_supervisor srw_supervisor_assertions #(.RESET_CYC(RESET_CYC),
	.NV_WRITE_CYC(NV_WRITE_CYC), .WDT_SEL10_CYC(WDT_SEL10_CYC),
	.WDT_SEL01_CYC(WDT_SEL01_CYC), .WDT_SEL00_CYC(WDT_SEL00_CYC))
	u_chk (.*);
`default_nettype wire

// file: srw_host_model.sv
/* Host model issuing write stops, latch sets and trip requests.
 Assumes a running mclk; requests change 1 ns after its edge. */
`timescale 1ns/1ps
`default_nettype none
module srw_host_model (
	input wire logic mclk,
	input wire logic nv_busy,
	input wire logic trip_program_done,
	output logic nv_write_stop,
	output logic write_enable_set,
	output logic trip_program_req
);
	initial {nv_write_stop, write_enable_set, trip_program_req} = 3'h0;
	// Fixed wait spans write time and trip recovery alike
	task automatic req(input logic [2:0] v, output int n, output logic d);
		@(posedge mclk) #1;
		{nv_write_stop, write_enable_set, trip_program_req} = v;
		@(posedge mclk) #1;
		{nv_write_stop, write_enable_set, trip_program_req} = 3'h0;
		n = nv_busy;
		d = 0;
		repeat (60) begin
			@(posedge mclk) #1;
			d |= trip_program_done;
			n += nv_busy;
		end
	endtask
endmodule
`default_nettype wire

// file: srw_supervisor_tb.sv
/* Bench: supervisor, host model and bound checker.
 Assumes shortened interval parameters. */
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor_tb;
	localparam int RST = 20, NV = 20;
	localparam int PER [4] = '{80, 60, 40, 0};
	logic mclk = 0, rst = 1, watchdog_kick = 0, write_enable_clr = 0, d;
	logic [1:0] nv_watchdog_sel = 2'h3;
	logic nv_write_stop, write_enable_set, trip_program_req, reset_out;
	logic nv_busy, write_enable_latch, trip_program_done;
	srw_pkg::srw_wdt_sel_t watchdog_sel;
	int mismatches = 0, n_compared = 0, n, m = 0;
	initial forever #5 mclk = ~mclk;
	srw_supervisor #(.RESET_CYC(RST), .NV_WRITE_CYC(NV),
		.TRIP_RECOVERY_CYC(30), .WDT_SEL10_CYC(40),
		.WDT_SEL01_CYC(60), .WDT_SEL00_CYC(80)) DUT (.*);
	srw_host_model host (.*);
	task automatic chk(input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %0t: saw %0h want %0h", $time, s, e);
		end
	endtask
	task automatic results;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wait_rst(input logic v);
		n = 0;
		do begin
			@(posedge mclk) #1;
			n++;
		end while (reset_out !== v && n < 300);
	endtask
	task automatic por(input logic [1:0] sel, input bit p);
		@(posedge mclk) #1 rst = 1;
		nv_watchdog_sel = sel;
		repeat (4) @(posedge mclk);
		#1 rst = 0;
		fork
			if (p) host.req(3'h6, m, d);
			wait_rst(1'b0);
		join
		chk((n - RST + 1) inside {[0:2]}, 1);
		chk(m + write_enable_latch, 0);
	endtask
	initial begin
		#200000;
		mismatches++;
		results();
	end
	initial begin
		void'($urandom(88));
		por(2'h3, 1);
		repeat (2) begin
			host.req(3'h4, n, d);
			chk(n, NV);
		end
		host.req(3'h1, n, d);
		chk(d, 0);
		host.req(3'h2, n, d);
		host.req(3'h1, n, d);
		chk(d, 1);
		host.req(3'h2, n, d);
		@(posedge mclk) #1 write_enable_clr = 1;
		@(posedge mclk) #1 write_enable_clr = 0;
		chk(write_enable_latch, 0);
		host.req(3'h1, n, d);
		chk(d, 0);
		for (int s = 0; s < 4; s++) begin
			por(s[1:0], 0);
			chk(watchdog_sel, s);
			repeat (6) begin
				repeat ($urandom_range(PER[s] / 2 + 4, 2)) @(posedge mclk);
				#1 watchdog_kick = 1;
				@(posedge mclk) #1 watchdog_kick = 0;
				chk(reset_out, 0);
			end
			wait_rst(1'b1);
			chk(s == 3 ? n == 300 : (n - PER[s] + 2) inside {[0:3]}, 1);
			wait_rst(1'b0);
			chk(s == 3 || (n - RST + 1) inside {[0:2]}, 1);
		end
		results();
	end
endmodule
`default_nettype wire
